// [hdl/qpo_pkg.sv]
// Register map, limits, timing counts and types of the quadrature output
package qpo_pkg;
   localparam int unsigned CLK_NS = 4;

   localparam logic [7:0] ADDR_PHASE = 8'h00;
   localparam logic [7:0] ADDR_PPR = 8'h04;
   localparam logic [7:0] ADDR_SRC = 8'h08;
   localparam logic [7:0] ADDR_ZPOL = 8'h0C;
   localparam logic [7:0] ADDR_WIDE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   localparam logic RST_PHASE = 1'h0;
   localparam logic [15:0] RST_PPR = 16'h09C4;
   localparam logic [1:0] RST_SRC = 2'h0;
   localparam logic RST_ZPOL = 1'h1;
   localparam logic [17:0] RST_WIDE = 18'h00000;

   localparam logic [1:0] SRC_ENC = 2'h0;
   localparam logic [1:0] SRC_REF = 2'h1;

   localparam logic [17:0] PPR_MIN = 18'h00023;
   localparam logic [17:0] PPR16_MAX = 18'h07FFF;
   localparam logic [20:0] ENC_CPR = 21'h100000;

   localparam int unsigned DIFF_MAX_PPS = 2_000_000;
   localparam int unsigned OC_MAX_PPS = 100_000;
   localparam int unsigned DIFF_PER_NS = 1_000_000_000 / DIFF_MAX_PPS;
   localparam int unsigned OC_PER_NS = 1_000_000_000 / OC_MAX_PPS;
   // Least spacing of two quadrature edges: a quarter output period
   localparam int unsigned EDGE_CYC =
      (DIFF_PER_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
   localparam int unsigned OC_CYC = (OC_PER_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] EDGE_LAST = 6'(EDGE_CYC - 1);
   localparam logic [11:0] OC_LOAD = 12'(OC_CYC - 1);
   localparam logic [11:0] OC_ACT_MIN = 12'(OC_CYC - OC_CYC / 2);
   localparam logic [1:0] Z_STEPS = 2'h2;

   typedef enum logic [1:0] {
      Q0 = 2'b00, Q1 = 2'b01, Q2 = 2'b11, Q3 = 2'b10
   } qpo_quad_t;

   typedef struct packed {
      logic quad_out_a;
      logic quad_out_b;
      logic index_out_diff;
      logic index_out_open_collector;
   } qpo_pins_t;

   typedef struct packed {
      logic phase;
      logic [15:0] ppr;
      logic [1:0] src;
      logic zpol;
      logic [17:0] wide;
   } qpo_cfg_t;
endpackage

// [hdl/qpo_quadrature_pulse_output.sv]
// Quadrature A/B/Z pulse output with Avalon-MM configuration registers
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Source 0 divides encoder, 1 follows reference pulses, other values inhibit.
// - Full closed loop stops output and hands the pins to scale input.
// - A and B are quadrature channels a quarter period apart.
// - Phase bit 0 makes A lead B forward; 1 makes A lag.
// - Reversing motion inverts the lead-lag relation for either phase.
// - Z polarity 0 drives Z high when valid; 1 drives it low.
// - Z changes on rising edge at polarity 0, falling at 1.
// - Pulses per revolution 35 to 32767, default 2500, before fourfold.
// - Wide count up to 262143 overrides when at least 35.
// - Z once per revolution, aligned with A at phase 0 and with B at phase 1, one A pulse wide.
// - At most 2 Mpps differential and 100 kpps open-collector Z.
module qpo_quadrature_pulse_output (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_enc_step,
   input wire logic i_enc_dir,
   input wire logic i_enc_index,
   input wire logic i_ref_step,
   input wire logic i_ref_dir,
   input wire logic i_full_closed,
   input wire logic i_pin_a,
   input wire logic i_pin_b,
   output var qpo_pkg::qpo_pins_t o_pins,
   output logic o_pins_oe,
   output logic o_scale_a,
   output logic o_scale_b
);
   import qpo_pkg::*;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [17:0] ppr_pick(input logic [15:0] p16,
      input logic [17:0] wide);
      logic [17:0] p;
      p = {2'h0, p16};
      if (p < PPR_MIN) begin
         p = PPR_MIN;
      end
      if (p > PPR16_MAX) begin
         p = PPR16_MAX;
      end
      if (wide >= PPR_MIN) begin
         p = wide;
      end
      return p;
   endfunction

   function automatic qpo_quad_t quad_step(input qpo_quad_t q,
      input logic up);
      qpo_quad_t n;
      n = q;
      unique case (q)
         Q0: n = up ? Q1 : Q3;
         Q1: n = up ? Q2 : Q0;
         Q2: n = up ? Q3 : Q1;
         Q3: n = up ? Q0 : Q2;
      endcase
      return n;
   endfunction

   // Register slave
   qpo_cfg_t cfg_q, cfg_d;
   logic done_q, done_d;
   logic [31:0] rdata_q, rdata_d;
   logic req;

   // Core state
   qpo_quad_t q_q, q_d;
   logic [20:0] acc_q, acc_d;
   logic signed [7:0] pend_q, pend_d;
   logic [5:0] since_q, since_d;
   logic idx_q, idx_d;
   logic z_act_q, z_act_d;
   logic [1:0] zcnt_q, zcnt_d;
   logic [11:0] oc_q, oc_d;
   qpo_pins_t pins_q, pins_d;
   logic oe_q, oe_d;
   logic scale_a_q, scale_a_d;
   logic scale_b_q, scale_b_d;
   logic [20:0] inc, sum;
   logic up, dn, go, go_up, enc_mode, run;

   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~done_q;
   assign o_avs_readdata = rdata_q;

   always_comb begin
      logic [31:0] m;
      m = '0;
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      done_d = req & ~done_q;
      if (req & ~done_q) begin
         case (i_avs_address)
            ADDR_PHASE: rdata_d = {31'h0, cfg_q.phase};
            ADDR_PPR: rdata_d = {16'h0, cfg_q.ppr};
            ADDR_SRC: rdata_d = {30'h0, cfg_q.src};
            ADDR_ZPOL: rdata_d = {31'h0, cfg_q.zpol};
            ADDR_WIDE: rdata_d = {14'h0, cfg_q.wide};
            ADDR_STATUS: rdata_d = {16'h0, pend_q, 4'h0, oe_q, z_act_q, q_q};
            default: rdata_d = '0;
         endcase
      end
      if (i_avs_write & done_q) begin
         case (i_avs_address)
            ADDR_PHASE: begin
               m = be_merge({31'h0, cfg_q.phase}, i_avs_writedata,
                  i_avs_byteenable);
               cfg_d.phase = m[0];
            end
            ADDR_PPR: begin
               m = be_merge({16'h0, cfg_q.ppr}, i_avs_writedata,
                  i_avs_byteenable);
               cfg_d.ppr = m[15:0];
            end
            ADDR_SRC: begin
               m = be_merge({30'h0, cfg_q.src}, i_avs_writedata,
                  i_avs_byteenable);
               cfg_d.src = m[1:0];
            end
            ADDR_ZPOL: begin
               m = be_merge({31'h0, cfg_q.zpol}, i_avs_writedata,
                  i_avs_byteenable);
               cfg_d.zpol = m[0];
            end
            ADDR_WIDE: begin
               m = be_merge({14'h0, cfg_q.wide}, i_avs_writedata,
                  i_avs_byteenable);
               cfg_d.wide = m[17:0];
            end
            default: m = '0;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_q <= '{RST_PHASE, RST_PPR, RST_SRC, RST_ZPOL, RST_WIDE};
         done_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   assign enc_mode = cfg_q.src == SRC_ENC;
   // Codes above 1 inhibit; closed loop stops generation
   assign run = ~i_full_closed & (enc_mode | cfg_q.src == SRC_REF);
   assign inc = {1'b0, ppr_pick(cfg_q.ppr, cfg_q.wide), 2'b00};
   assign sum = acc_q + inc;
   // Edges paced to the differential rate limit
   assign go = run & (pend_q != 8'sh00) & (since_q >= EDGE_LAST);
   assign go_up = ~pend_q[7];

   always_comb begin
      acc_d = acc_q;
      up = 1'b0;
      dn = 1'b0;
      // Fractional divider, one step per overflow either way
      if (run & enc_mode & i_enc_step) begin
         if (i_enc_dir) begin
            if (sum >= ENC_CPR) begin
               acc_d = sum - ENC_CPR;
               up = 1'b1;
            end else begin
               acc_d = sum;
            end
         end else if (acc_q >= inc) begin
            acc_d = acc_q - inc;
         end else begin
            acc_d = acc_q + ENC_CPR - inc;
            dn = 1'b1;
         end
      end
      if (run & ~enc_mode & i_ref_step) begin
         up = i_ref_dir;
         dn = ~i_ref_dir;
      end
      pend_d = pend_q;
      if (up) begin
         pend_d = pend_d + 8'sh01;
      end
      if (dn) begin
         pend_d = pend_d - 8'sh01;
      end
      if (go) begin
         pend_d = go_up ? pend_d - 8'sh01 : pend_d + 8'sh01;
      end
      since_d = since_q;
      if (go) begin
         since_d = '0;
      end else if (since_q < EDGE_LAST) begin
         since_d = since_q + 6'h01;
      end
      // Reverse steps walk the Gray ring backwards
      q_d = go ? quad_step(q_q, go_up) : q_q;

      // Index waits for q[0] to rise (A at phase 0, B at phase 1), then lasts two steps
      idx_d = idx_q | (run & enc_mode & i_enc_index);
      z_act_d = z_act_q;
      zcnt_d = zcnt_q;
      if (go & z_act_q) begin
         zcnt_d = zcnt_q - 2'h1;
         z_act_d = zcnt_q != 2'h1;
      end else if (go & idx_q & q_d[0] & ~q_q[0]) begin
         z_act_d = 1'b1;
         zcnt_d = Z_STEPS;
         idx_d = run & enc_mode & i_enc_index;
      end
      if (~run | ~enc_mode) begin
         idx_d = 1'b0;
         z_act_d = 1'b0;
         zcnt_d = '0;
      end

      // Open-collector copy starts no faster than its rate limit
      oc_d = oc_q;
      if (oc_q != 12'h000) begin
         oc_d = oc_q - 12'h001;
      end else if (z_act_d & ~z_act_q) begin
         oc_d = OC_LOAD;
      end

      // Phase bit swaps channels; A is q[0], B is q[1]
      pins_d.quad_out_a = run & (cfg_q.phase ? q_q[1] : q_q[0]);
      pins_d.quad_out_b = run & (cfg_q.phase ? q_q[0] : q_q[1]);
      // Inactive level equals the polarity bit
      pins_d.index_out_diff = z_act_q ^ cfg_q.zpol;
      pins_d.index_out_open_collector =
         (oc_q >= OC_ACT_MIN) ^ cfg_q.zpol;
      oe_d = ~i_full_closed;
      scale_a_d = i_pin_a;
      scale_b_d = i_pin_b;
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q_q <= Q0;
         acc_q <= '0;
         pend_q <= '0;
         since_q <= '0;
         idx_q <= 1'b0;
         z_act_q <= 1'b0;
         zcnt_q <= '0;
         oc_q <= '0;
         pins_q <= '{1'b0, 1'b0, RST_ZPOL, RST_ZPOL};
         oe_q <= 1'b0;
         scale_a_q <= 1'b0;
         scale_b_q <= 1'b0;
      end else begin
         q_q <= q_d;
         acc_q <= acc_d;
         pend_q <= pend_d;
         since_q <= since_d;
         idx_q <= idx_d;
         z_act_q <= z_act_d;
         zcnt_q <= zcnt_d;
         oc_q <= oc_d;
         pins_q <= pins_d;
         oe_q <= oe_d;
         scale_a_q <= scale_a_d;
         scale_b_q <= scale_b_d;
      end
   end

   assign o_pins = pins_q;
   assign o_pins_oe = oe_q;
   assign o_scale_a = scale_a_q;
   assign o_scale_b = scale_b_q;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   chk_off_quiet:
   assert property (!run [*2] |-> !o_pins.quad_out_a && !o_pins.quad_out_b)
      else $error("A/B not idle while inhibited");
   chk_closed_oe:
   assert property (i_full_closed |=> !o_pins_oe)
      else $error("pins driven in closed loop");
   chk_gray_step:
   assert property (go |=> $countones(q_q ^ $past(q_q)) == 1)
      else $error("quadrature step not one bit");
   chk_a_leads:
   assert property (go && go_up && !cfg_q.phase && q_q == Q0 ##1 run
      |=> o_pins.quad_out_a && !o_pins.quad_out_b)
      else $error("A does not lead forward");
   chk_b_leads_rev:
   assert property (go && !go_up && !cfg_q.phase && q_q == Q0 ##1 run
      |=> !o_pins.quad_out_a && o_pins.quad_out_b)
      else $error("B does not lead in reverse");
   chk_z_idle:
   assert property (!z_act_q |=> o_pins.index_out_diff == $past(cfg_q.zpol))
      else $error("index not at idle level");
   chk_ppr_choice:
   assert property (1'b1 |-> ((cfg_q.wide >= PPR_MIN) ?
      inc[19:2] == cfg_q.wide :
      (inc[19:2] >= PPR_MIN && inc[19:2] <= PPR16_MAX)))
      else $error("wrong pulses per revolution");
   chk_edge_gap:
   assert property (go |=> !go [*8])
      else $error("quadrature edges too close");
   chk_oc_rate:
   assert property (oc_q == OC_LOAD |-> $past(oc_q) == 12'h000)
      else $error("open-collector index restarted early");
   chk_z_width:
   assert property ($fell(z_act_q) && run && enc_mode |-> $past(go))
      else $error("index ended off a step");
   chk_acc_step:
   assert property (run && enc_mode && i_enc_step && i_enc_dir &&
      sum >= ENC_CPR && !go |=> pend_q == $past(pend_q) + 8'sh01)
      else $error("overflow lost");

   cov_fwd_step: cover property (go && go_up);
   cov_rev_step: cover property (go && !go_up);
   cov_index: cover property ($rose(z_act_q));
endmodule

`default_nettype wire

// [test/qpo_host_model.sv]
// Host model counting quadrature edges and index pulses
`timescale 1ns/1ns
`default_nettype none
module qpo_host_model (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire qpo_pkg::qpo_pins_t i_pins,
   input wire logic i_zpol,
   output int o_count,
   output int o_zcount
);
   import qpo_pkg::*;
   logic [1:0] ab_q;
   logic z_q;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ab_q <= 2'h0;
         z_q <= 1'h1;
         o_count <= 0;
         o_zcount <= 0;
      end else begin
         ab_q <= {i_pins.quad_out_a, i_pins.quad_out_b};
         z_q <= i_pins.index_out_diff;
         // A ahead of B counts up
         case ({ab_q, i_pins.quad_out_a, i_pins.quad_out_b})
            4'h2, 4'hB, 4'hD, 4'h4: o_count <= o_count + 1;
            4'h1, 4'h7, 4'hE, 4'h8: o_count <= o_count - 1;
            default: ;
         endcase
         // Latch on the trailing edge of Z
         if (z_q != i_pins.index_out_diff && i_pins.index_out_diff == i_zpol)
            o_zcount <= o_zcount + 1;
      end
   end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the quadrature pulse output
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import qpo_pkg::*;
   logic i_clock = 1'h0;
   logic i_sys_rst = 1'h1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'h0;
   logic i_avs_write = 1'h0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_enc_step = 1'h0, i_enc_dir = 1'h1, i_enc_index = 1'h0;
   logic i_ref_step = 1'h0, i_ref_dir = 1'h1, i_full_closed = 1'h0;
   logic i_pin_a = 1'h0, i_pin_b = 1'h0, zpol = 1'h1;
   logic [31:0] o_avs_readdata;
   logic [31:0] rd;
   logic o_avs_waitrequest, o_pins_oe, o_scale_a, o_scale_b;
   qpo_pins_t o_pins;
   int count, zcount, failures = 0, tests_run = 0;
   longint acc = 0;

   always #2 i_clock = ~i_clock;

   qpo_quadrature_pulse_output dut_u (.i_clock, .i_sys_rst, .i_avs_address,
      .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
      .o_avs_readdata, .o_avs_waitrequest, .i_enc_step, .i_enc_dir,
      .i_enc_index, .i_ref_step, .i_ref_dir, .i_full_closed, .i_pin_a,
      .i_pin_b, .o_pins, .o_pins_oe, .o_scale_a, .o_scale_b);
   qpo_host_model host_u (.i_clock, .i_sys_rst, .i_pins(o_pins),
      .i_zpol(zpol), .o_count(count), .o_zcount(zcount));

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge i_clock);
      i_avs_read <= ~wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= wd;
      i_avs_byteenable <= be;
      // Hold until waitrequest is seen low at a rising edge
      do begin
         @(posedge i_clock);
         n++;
         if (n > 20) begin
            failures++;
            wrap_up();
         end
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
   endtask

   task automatic steps(input logic enc, input int n, input logic dir,
         input longint inc);
      repeat (n) begin
         @(posedge i_clock);
         i_enc_step <= enc;
         i_ref_step <= ~enc;
         i_enc_dir <= dir;
         i_ref_dir <= dir;
         @(posedge i_clock);
         i_enc_step <= 1'h0;
         i_ref_step <= 1'h0;
         acc += inc;
         repeat (40) @(posedge i_clock);
      end
   endtask

   task automatic t_reset;
      bus(1'h0, ADDR_PHASE, 32'h0, 4'hF);
      check("phase", rd, 32'(RST_PHASE));
      bus(1'h0, ADDR_PPR, 32'h0, 4'hF);
      check("ppr", rd, 32'h000009C4);
      bus(1'h0, ADDR_SRC, 32'h0, 4'hF);
      check("src", rd, 32'(RST_SRC));
      bus(1'h0, ADDR_ZPOL, 32'h0, 4'hF);
      check("zpol", rd, 32'h00000001);
      bus(1'h0, ADDR_WIDE, 32'h0, 4'hF);
      check("wide", rd, 32'(RST_WIDE));
      bus(1'h1, 8'h18, 32'hFFFFFFFF, 4'hF);
      bus(1'h0, 8'h18, 32'h0, 4'hF);
      check("unmapped", rd, 32'h0);
      check("z idle", 32'(o_pins.index_out_diff), 32'h1);
   endtask

   task automatic t_ref;
      int c;
      // Reference mode for synchronous tracking
      bus(1'h1, ADDR_SRC, 32'h1, 4'hF);
      c = count;
      steps(1'h0, 4, 1'h1, 0);
      check("fwd lead", 32'(count - c), 32'h4);
      steps(1'h0, 4, 1'h0, 0);
      check("rev lead", 32'(count - c), 32'h0);
      bus(1'h1, ADDR_PHASE, 32'h1, 4'hF);
      steps(1'h0, 4, 1'h1, 0);
      check("fwd lag", 32'(count - c), 32'hFFFFFFFC);
      steps(1'h0, 4, 1'h0, 0);
      bus(1'h1, ADDR_PHASE, 32'h0, 4'hF);
   endtask

   task automatic t_burst;
      int c;
      // Backlog drains one edge per quarter period
      bus(1'h1, ADDR_SRC, 32'h1, 4'hF);
      c = count;
      @(posedge i_clock);
      i_ref_dir <= 1'h1;
      i_ref_step <= 1'h1;
      repeat (4) @(posedge i_clock);
      i_ref_step <= 1'h0;
      repeat (46) @(posedge i_clock);
      check("paced", 32'(count - c), 32'h2);
      repeat (100) @(posedge i_clock);
      check("drained", 32'(count - c), 32'h4);
   endtask

   task automatic t_inhibit;
      int c;
      for (int s = 2; s < 4; s++) begin
         bus(1'h1, ADDR_SRC, 32'(s), 4'hF);
         c = count;
         steps(1'h0, 2, 1'h1, 0);
         steps(1'h1, 2, 1'h1, 0);
         check("inhibit", 32'(count - c), 32'h0);
         check("ab low", 32'(o_pins[3:2]), 32'h0);
      end
   endtask

   task automatic t_closed;
      int c;
      bus(1'h1, ADDR_SRC, 32'h1, 4'hF);
      i_full_closed <= 1'h1;
      i_pin_a <= 1'h1;
      repeat (4) @(posedge i_clock);
      check("oe", 32'(o_pins_oe), 32'h0);
      check("scale", 32'({o_scale_a, o_scale_b}), 32'h2);
      c = count;
      steps(1'h0, 2, 1'h1, 0);
      check("closed", 32'(count - c), 32'h0);
      i_full_closed <= 1'h0;
      i_pin_a <= 1'h0;
      repeat (4) @(posedge i_clock);
      check("oe back", 32'(o_pins_oe), 32'h1);
   endtask

   task automatic t_enc;
      int c, z;
      longint e;
      bus(1'h1, ADDR_SRC, 32'h0, 4'hF);
      bus(1'h1, ADDR_WIDE, 32'h22, 4'hF);
      bus(1'h1, ADDR_PPR, 32'hFFFF7FFF, 4'h3);
      c = count;
      e = acc >> 20;
      steps(1'h1, 9, 1'h1, 4 * 32767);
      e = (acc >> 20) - e;
      check("ppr16", 32'(count - c), 32'(e));
      @(posedge i_clock);
      i_enc_index <= 1'h1;
      @(posedge i_clock);
      i_enc_index <= 1'h0;
      bus(1'h1, ADDR_WIDE, 32'h0003FFFF, 4'hF);
      c = count;
      z = zcount;
      e = acc >> 20;
      steps(1'h1, 16, 1'h1, 4 * 262143);
      repeat (100) @(posedge i_clock);
      check("wide", 32'(count - c), 32'((acc >> 20) - e));
      check("z once", 32'(zcount - z), 32'h1);
      check("oc active", 32'(o_pins.index_out_open_collector), 32'h0);
      repeat (800) @(posedge i_clock);
      check("oc idle", 32'(o_pins.index_out_open_collector), 32'h1);
   endtask

   task automatic t_zpol;
      bus(1'h1, ADDR_ZPOL, 32'h0, 4'hF);
      zpol <= 1'h0;
      repeat (4) @(posedge i_clock);
      check("z idle low", 32'(o_pins.index_out_diff), 32'h0);
   endtask

   initial begin
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 1'h0;
      repeat (2) @(posedge i_clock);
      t_reset();
      t_ref();
      t_burst();
      t_inhibit();
      t_closed();
      t_enc();
      t_zpol();
      wrap_up();
   end
endmodule
`default_nettype wire
